// [lbd_dma_port.sv]
// bus-side dma cycle timing, slave register strobes and remote latch handshake
`timescale 1ns/10ps
// Overview of operation
// - read strobe low, data taken at its rise
// - read strobe floats until bus grant
// - slave write strobe rise writes addressed register
// - slave read low drives selected register out
// - acknowledge low only once access is synchronized
// - four states t1 to t4 per cycle
// - ready sampled in third state
// - each wait state adds one clock
// - read done starts memory read refilling latch
// - port write strobe rises with valid data
// - register address used only while selected
// - write strobe low, rises with valid data
// - write done starts memory write from latch
module lbd_dma_port
  import lbd_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // bus ownership
  input wire logic BUS_GRANT,
  output logic BUS_REQUEST_OUT,
  // multiplexed local bus
  input wire logic [LBD_DW-1:0] AD_I,
  output logic [LBD_DW-1:0] AD_O,
  output logic AD_LO_OE,
  output logic AD_HI_OE,
  input wire logic READY,
  // memory and latch strobes
  output logic MASTER_READ_STROBE_N,
  output logic MASTER_READ_STROBE_OE,
  output logic MASTER_WRITE_STROBE_N,
  output logic MASTER_WRITE_STROBE_OE,
  output logic PORT_WRITE_STROBE_N,
  output logic PORT_READ_ENABLE_N,
  // remote dma latch handshake
  input wire logic LATCH_READ_DONE,
  input wire logic LATCH_WRITE_DONE,
  input wire logic REM_LOAD,
  input wire logic [LBD_AW-1:0] REM_ADDR,
  // slave register port
  input wire logic CS_N,
  input wire logic SLAVE_RD_N,
  input wire logic SLAVE_WR_N,
  input wire logic [LBD_RAW-1:0] REGISTER_ADDRESS_INPUTS,
  output logic ACK_N,
  output logic [LBD_RAW-1:0] REG_ADDR,
  input wire logic [LBD_RDW-1:0] REG_RDATA,
  output logic REG_WE,
  output logic [LBD_RDW-1:0] REG_WDATA,
  // local dma requests
  input wire logic LW_REQ,
  input wire logic [LBD_AW-1:0] LW_ADDR,
  input wire logic [LBD_DW-1:0] LW_DATA,
  input wire logic LR_REQ,
  input wire logic [LBD_AW-1:0] LR_ADDR,
  output logic DMA_DONE,
  // read data stream
  output logic RD_VALID,
  output logic [LBD_DW-1:0] RD_DATA,
  input wire logic RD_READY
);
  lbd_state_t state_q, state_d;
  lbd_kind_t kind_q, kind_d, sel_kind;
  logic [LBD_AW-1:0] addr_q, rem_addr_q;
  logic [LBD_DW-1:0] wdata_q, ad_q, cap_q;
  logic latch_read_done_pend_q, latch_write_done_pend_q, push_q, done_q;
  logic mrd_n_q, mwr_n_q, pwr_n_q, prd_n_q, moe_q, bus_request_out_q;
  logic ad_lo_oe_q, ad_hi_oe_q;
  logic slv_sync_q, ack_n_q, wr_low_q, we_q;
  logic [LBD_RDW-1:0] sdata_q, wbyte_q;
  logic [LBD_RAW-1:0] raddr_q;

  lbd_stream_if buf_in ();
  lbd_stream_if buf_out ();

  lbd_rd_buf u_buf (
    .clk(CLK),
    .rst(RST),
    .in_s(buf_in.snk),
    .out_s(buf_out.src)
  );

  // slave access decode; dma never starts while a cpu access is open
  wire slv_busy = !CS_N && (!SLAVE_RD_N || !SLAVE_WR_N);
  wire slv_ok = slv_busy && (state_q == S_IDLE);
  wire slv_acked = slv_ok && slv_sync_q;
  wire slv_rd_drive = slv_acked && !SLAVE_RD_N;
  wire slv_wr_rise = wr_low_q && SLAVE_WR_N;

  // a local read is only started when the buffer has room for its word
  wire lr_go = LR_REQ && buf_in.ready && !push_q;
  wire any_work = latch_write_done_pend_q || latch_read_done_pend_q || LW_REQ || lr_go;
  wire start = (state_q == S_IDLE) && BUS_GRANT && !slv_busy && !slv_sync_q && any_work;
  wire leave_wait = lbd_sample_state(state_q) && !READY;
  wire is_read_d = (kind_d == K_LRD) || (kind_d == K_RRD);
  wire is_write_d = (kind_d == K_LWR) || (kind_d == K_RWR);
  wire stb_d = lbd_strobe_state(state_d);
  wire data_ph_d = stb_d || (state_d == S_T4);
  wire [LBD_AW-1:0] start_addr = (sel_kind == K_LWR) ? LW_ADDR :
                                 (sel_kind == K_LRD) ? LR_ADDR : rem_addr_q;

  assign sel_kind = latch_write_done_pend_q ? K_RWR : latch_read_done_pend_q ? K_RRD : LW_REQ ? K_LWR : K_LRD;
  assign kind_d = start ? sel_kind : kind_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: state_d = start ? S_T1 : S_IDLE;
      S_T1: state_d = S_T2;
      S_T2: state_d = S_T3;
      S_T3: state_d = READY ? S_TW : S_T4;
      S_TW: state_d = READY ? S_TW : S_T4;
      S_T4: state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= S_IDLE;
      kind_q <= K_LRD;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
    end
  end

  // cycle address, write data and remote address counter
  always_ff @(posedge CLK) begin
    if (RST) begin
      addr_q <= LBD_ADDR_RST;
      wdata_q <= LBD_DATA_RST;
      rem_addr_q <= LBD_ADDR_RST;
    end else begin
      if (start) begin
        addr_q <= start_addr;
        wdata_q <= LW_DATA;
      end
      if (REM_LOAD) begin
        rem_addr_q <= REM_ADDR;
      end else if (start && (sel_kind == K_RRD || sel_kind == K_RWR)) begin
        rem_addr_q <= rem_addr_q + LBD_ADDR_STEP;
      end
    end
  end

  // latch handshake flags: a new done pulse wins over the clear at start
  always_ff @(posedge CLK) begin
    if (RST) begin
      latch_read_done_pend_q <= 1'b0;
      latch_write_done_pend_q <= 1'b0;
    end else begin
      latch_read_done_pend_q <= LATCH_READ_DONE || (latch_read_done_pend_q && !(start && sel_kind == K_RRD));
      latch_write_done_pend_q <= LATCH_WRITE_DONE || (latch_write_done_pend_q && !(start && sel_kind == K_RWR));
    end
  end

  // strobes and bus registered from next state so every edge is clean
  always_ff @(posedge CLK) begin
    if (RST) begin
      mrd_n_q <= LBD_STB_IDLE;
      mwr_n_q <= LBD_STB_IDLE;
      pwr_n_q <= LBD_STB_IDLE;
      prd_n_q <= LBD_STB_IDLE;
      moe_q <= 1'b0;
      ad_q <= LBD_DATA_RST;
      ad_lo_oe_q <= 1'b0;
      ad_hi_oe_q <= 1'b0;
      bus_request_out_q <= 1'b0;
    end else begin
      moe_q <= BUS_GRANT;
      mrd_n_q <= !(stb_d && is_read_d);
      mwr_n_q <= !(stb_d && is_write_d);
      pwr_n_q <= !(stb_d && kind_d == K_RRD);
      prd_n_q <= !(data_ph_d && kind_d == K_RWR);
      ad_hi_oe_q <= (state_d == S_T1) || (data_ph_d && kind_d == K_LWR);
      ad_lo_oe_q <= (state_d == S_T1) || (data_ph_d && kind_d == K_LWR) || slv_rd_drive;
      if (state_d == S_T1) begin
        ad_q <= start_addr;
      end else if (slv_rd_drive) begin
        ad_q <= {8'h00, REG_RDATA};
      end else if (data_ph_d && kind_d == K_LWR) begin
        ad_q <= wdata_q;
      end
      bus_request_out_q <= any_work || (state_d != S_IDLE);
    end
  end

  // read data taken on the edge where the read strobe rises
  always_ff @(posedge CLK) begin
    if (RST) begin
      push_q <= 1'b0;
      cap_q <= LBD_DATA_RST;
      done_q <= 1'b0;
    end else begin
      push_q <= leave_wait && (kind_q == K_LRD);
      done_q <= leave_wait && (kind_q == K_LRD || kind_q == K_LWR);
      if (leave_wait && kind_q == K_LRD) begin
        cap_q <= AD_I;
      end
    end
  end

  assign buf_in.valid = push_q;
  assign buf_in.data = cap_q;
  assign buf_out.ready = RD_READY;

  // slave port: one stage of synchronization before acknowledge
  always_ff @(posedge CLK) begin
    if (RST) begin
      slv_sync_q <= 1'b0;
      ack_n_q <= 1'b1;
      wr_low_q <= 1'b0;
      we_q <= 1'b0;
      sdata_q <= LBD_BYTE_RST;
      wbyte_q <= LBD_BYTE_RST;
      raddr_q <= LBD_RADDR_RST;
    end else begin
      slv_sync_q <= slv_ok;
      ack_n_q <= !slv_acked;
      wr_low_q <= slv_acked && !SLAVE_WR_N;
      if (!CS_N) begin
        raddr_q <= REGISTER_ADDRESS_INPUTS;
      end
      if (slv_acked && !SLAVE_WR_N) begin
        sdata_q <= AD_I[LBD_RDW-1:0];
      end
      we_q <= slv_wr_rise;
      if (slv_wr_rise) begin
        wbyte_q <= sdata_q;
      end
    end
  end

  assign BUS_REQUEST_OUT = bus_request_out_q;
  assign AD_O = ad_q;
  assign AD_LO_OE = ad_lo_oe_q;
  assign AD_HI_OE = ad_hi_oe_q;
  assign MASTER_READ_STROBE_N = mrd_n_q;
  assign MASTER_READ_STROBE_OE = moe_q;
  assign MASTER_WRITE_STROBE_N = mwr_n_q;
  assign MASTER_WRITE_STROBE_OE = moe_q;
  assign PORT_WRITE_STROBE_N = pwr_n_q;
  assign PORT_READ_ENABLE_N = prd_n_q;
  assign ACK_N = ack_n_q;
  assign REG_ADDR = raddr_q;
  assign REG_WE = we_q;
  assign REG_WDATA = wbyte_q;
  assign DMA_DONE = done_q;
  assign RD_VALID = buf_out.valid;
  assign RD_DATA = buf_out.data;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  chk_strobe_float: assert property (
    !BUS_GRANT |=> !MASTER_READ_STROBE_OE && !MASTER_WRITE_STROBE_OE)
    else $error("memory strobes enabled without grant");
  chk_read_capture: assert property (
    $rose(MASTER_READ_STROBE_N) && kind_q == K_LRD |-> push_q && cap_q == $past(AD_I))
    else $error("read data not taken at strobe rise");
  chk_four_states: assert property (
    state_q == S_T1 |=> state_q == S_T2 ##1 state_q == S_T3 ##1 (state_q == S_T4 || state_q == S_TW))
    else $error("cycle states out of order");
  chk_ready_wait: assert property (
    lbd_sample_state(state_q) && READY |=> state_q == S_TW)
    else $error("ready high did not insert a wait state");
  chk_wait_length: assert property (
    lbd_sample_state(state_q) && !READY |=> state_q == S_T4 ##1 state_q == S_IDLE)
    else $error("cycle not ended after ready low");
  chk_wait_hold: assert property (
    state_q == S_TW |-> $stable(MASTER_READ_STROBE_N) && $stable(MASTER_WRITE_STROBE_N)
      && $stable(AD_O) && $stable(AD_LO_OE))
    else $error("bus changed during wait state");
  chk_write_rise: assert property (
    $rose(MASTER_WRITE_STROBE_N) |-> state_q == S_T4 && (kind_q == K_LWR || kind_q == K_RWR))
    else $error("write strobe rose outside t4");
  chk_port_write: assert property (
    $rose(PORT_WRITE_STROBE_N) |-> state_q == S_T4 && kind_q == K_RRD && !$past(READY))
    else $error("port write strobe rose off data");
  chk_ack_sync: assert property (
    $fell(ACK_N) |-> $past(slv_ok, 1) && $past(slv_ok, 2))
    else $error("acknowledge before synchronization");
  chk_reg_write: assert property (
    wr_low_q && SLAVE_WR_N |=> REG_WE && REG_WDATA == $past(sdata_q))
    else $error("slave write strobe rise not committed");
  chk_addr_ignored: assert property (
    CS_N |=> $stable(REG_ADDR))
    else $error("register address taken while deselected");
  chk_latch_read_done_start: assert property (
    LATCH_READ_DONE && !LATCH_WRITE_DONE && !latch_write_done_pend_q |=> ##[0:20] (state_q == S_T1 && kind_q == K_RRD)
      or (state_q == S_IDLE && !BUS_GRANT))
    else $error("read done did not start a refill");
  chk_latch_write_done_start: assert property (
    latch_write_done_pend_q && start |=> state_q == S_T1 && kind_q == K_RWR ##1 !PORT_READ_ENABLE_N)
    else $error("write done did not start a latch write");
endmodule

// [lbd_mem_model.sv]
// buffer memory, ready source, external latch and host data driver
`timescale 1ns/10ps
module lbd_mem_model
  import lbd_pkg::*;
(
  // clock
  input wire logic clk,
  // device side
  input wire logic mrd_n,
  input wire logic mwr_n,
  input wire logic pwr_n,
  input wire logic prd_n,
  input wire logic lo_oe,
  input wire logic hi_oe,
  input wire logic [LBD_DW-1:0] ad_o,
  output logic [LBD_DW-1:0] ad_i,
  output logic ready,
  // bench side
  input wire logic [3:0] waits,
  input wire logic host_oe,
  input wire logic [LBD_RDW-1:0] host_d,
  input wire logic [LBD_DW-1:0] lat_in,
  output logic [LBD_DW-1:0] lat_q,
  output logic [LBD_DW-1:0] wr_q,
  output logic [LBD_AW-1:0] wa_q
);
  logic [LBD_AW-1:0] adr_q;
  logic [3:0] cnt_q;
  logic [LBD_DW-1:0] flt_q = 16'h0000;
  wire idle = mrd_n && mwr_n;
  wire [LBD_DW-1:0] bus = (lo_oe || hi_oe) ? ad_o : ad_i;
  // released lines toggle so a stale word never passes for data
  assign ad_i = !mrd_n ? (adr_q ^ 16'h5A3C) : !prd_n ? lat_in :
    host_oe ? {~flt_q[15:8], host_d} : ~flt_q;
  assign ready = !idle && cnt_q >= 4'h1 && cnt_q <= waits;
  always_ff @(posedge clk) begin
    flt_q <= ad_i;
    cnt_q <= idle ? 4'h0 : cnt_q + 4'h1;
    if (lo_oe && hi_oe && idle)
      adr_q <= ad_o;
    if (!pwr_n)
      lat_q <= bus;
    if (!mwr_n)
      wr_q <= bus;
    if (!mwr_n)
      wa_q <= adr_q;
  end
endmodule

// [lbd_pkg.sv]
// shared constants, types and decode helpers for the local bus dma block
package lbd_pkg;
  localparam int LBD_AW = 16;
  localparam int LBD_DW = 16;
  localparam int LBD_RDW = 8;
  localparam int LBD_RAW = 4;
  localparam logic LBD_STB_IDLE = 1'b1;
  localparam logic [LBD_AW-1:0] LBD_ADDR_RST = 16'h0000;
  localparam logic [LBD_DW-1:0] LBD_DATA_RST = 16'h0000;
  localparam logic [LBD_RDW-1:0] LBD_BYTE_RST = 8'h00;
  localparam logic [LBD_RAW-1:0] LBD_RADDR_RST = 4'h0;
  localparam logic [LBD_AW-1:0] LBD_ADDR_STEP = 16'h0001;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_T1 = 6'h02,
    S_T2 = 6'h04,
    S_T3 = 6'h08,
    S_TW = 6'h10,
    S_T4 = 6'h20
  } lbd_state_t;

  typedef enum logic [1:0] {
    K_LRD = 2'h0,
    K_LWR = 2'h1,
    K_RRD = 2'h2,
    K_RWR = 2'h3
  } lbd_kind_t;

  // states in which a memory strobe is held low
  function automatic logic lbd_strobe_state(input lbd_state_t st);
    lbd_strobe_state = (st == S_T2) || (st == S_T3) || (st == S_TW);
  endfunction

  // states in which the ready input is sampled
  function automatic logic lbd_sample_state(input lbd_state_t st);
    lbd_sample_state = (st == S_T3) || (st == S_TW);
  endfunction
endpackage

// [lbd_rd_buf.sv]
// two-entry buffer for words read from buffer memory
`timescale 1ns/10ps
module lbd_rd_buf
  import lbd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // streams
  lbd_stream_if.snk in_s,
  lbd_stream_if.src out_s
);
  logic [LBD_DW-1:0] d0_q;
  logic [LBD_DW-1:0] d1_q;
  logic v0_q;
  logic v1_q;
  wire push = in_s.valid && !v1_q;
  wire pop = v0_q && out_s.ready;

  assign in_s.ready = !v1_q;
  assign out_s.valid = v0_q;
  assign out_s.data = d0_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      v0_q <= 1'b0;
      v1_q <= 1'b0;
      d0_q <= LBD_DATA_RST;
      d1_q <= LBD_DATA_RST;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (!v0_q) begin
            d0_q <= in_s.data;
            v0_q <= 1'b1;
          end else begin
            d1_q <= in_s.data;
            v1_q <= 1'b1;
          end
        end
        2'b01: begin
          d0_q <= d1_q;
          v0_q <= v1_q;
          v1_q <= 1'b0;
        end
        2'b11: begin
          // head leaves while a word arrives: occupancy is unchanged
          if (v1_q) begin
            d0_q <= d1_q;
            d1_q <= in_s.data;
          end else begin
            d0_q <= in_s.data;
          end
        end
        default: begin
          v0_q <= v0_q;
        end
      endcase
    end
  end
endmodule

// [lbd_stream_if.sv]
// valid/ready word stream between the dma core and its read buffer
`timescale 1ns/10ps
interface lbd_stream_if;
  import lbd_pkg::*;
  logic valid;
  logic ready;
  logic [LBD_DW-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [local_bus_dma_and_slave_port_tb.sv]
// self-checking bench for the local bus dma and slave port
`timescale 1ns/10ps
module local_bus_dma_and_slave_port_tb;
  import lbd_pkg::*;
  localparam logic [LBD_DW-1:0] K = 16'h5A3C;
  logic CLK = 1'h0, RST = 1'h1, BUS_GRANT = 1'h0, READY, REM_LOAD = 1'h0;
  logic LATCH_READ_DONE = 1'h0, LATCH_WRITE_DONE = 1'h0, CS_N = 1'h1;
  logic SLAVE_RD_N = 1'h1, SLAVE_WR_N = 1'h1, LW_REQ = 1'h0, LR_REQ = 1'h0;
  logic RD_READY = 1'h1, host_oe = 1'h0;
  logic [LBD_RAW-1:0] REGISTER_ADDRESS_INPUTS = 4'h0, REG_ADDR;
  logic [LBD_AW-1:0] REM_ADDR = 16'h0800, LW_ADDR = 16'h0456, LR_ADDR = 16'h0000, wa_q;
  logic [LBD_DW-1:0] AD_I, AD_O, RD_DATA, LW_DATA = 16'hBEEF, lat_in = 16'hCAFE, lat_q, wr_q;
  logic [3:0] waits = 4'h0;
  logic BUS_REQUEST_OUT, AD_LO_OE, AD_HI_OE, MASTER_READ_STROBE_N, MASTER_READ_STROBE_OE;
  logic MASTER_WRITE_STROBE_N, MASTER_WRITE_STROBE_OE, PORT_WRITE_STROBE_N;
  logic PORT_READ_ENABLE_N, ACK_N, REG_WE, DMA_DONE, RD_VALID;
  logic [LBD_RDW-1:0] REG_WDATA, host_d = 8'h5D;
  wire [LBD_RDW-1:0] REG_RDATA = {4'hC, REG_ADDR};
  // floating strobes read high on the board
  wire mrd_w = MASTER_READ_STROBE_OE ? MASTER_READ_STROBE_N : 1'h1;
  wire mwr_w = MASTER_WRITE_STROBE_OE ? MASTER_WRITE_STROBE_N : 1'h1;
  int error_cnt = 0, num_checks = 0, cyc = 0, n;
  lbd_dma_port uut (
    .CLK, .RST, .BUS_GRANT, .BUS_REQUEST_OUT, .AD_I, .AD_O, .AD_LO_OE, .AD_HI_OE,
    .READY, .MASTER_READ_STROBE_N, .MASTER_READ_STROBE_OE, .MASTER_WRITE_STROBE_N,
    .MASTER_WRITE_STROBE_OE, .PORT_WRITE_STROBE_N, .PORT_READ_ENABLE_N,
    .LATCH_READ_DONE, .LATCH_WRITE_DONE, .REM_LOAD, .REM_ADDR, .CS_N, .SLAVE_RD_N,
    .SLAVE_WR_N, .REGISTER_ADDRESS_INPUTS, .ACK_N, .REG_ADDR, .REG_RDATA, .REG_WE,
    .REG_WDATA, .LW_REQ, .LW_ADDR, .LW_DATA, .LR_REQ, .LR_ADDR, .DMA_DONE,
    .RD_VALID, .RD_DATA, .RD_READY
  );
  lbd_mem_model mem (
    .clk(CLK), .mrd_n(mrd_w), .mwr_n(mwr_w), .pwr_n(PORT_WRITE_STROBE_N),
    .prd_n(PORT_READ_ENABLE_N), .lo_oe(AD_LO_OE), .hi_oe(AD_HI_OE), .ad_o(AD_O),
    .ad_i(AD_I), .ready(READY), .waits, .host_oe, .host_d, .lat_in, .lat_q, .wr_q, .wa_q
  );
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'h1) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask
  // edges until the chosen event, bounded at 50
  task automatic wait_for(input int k, output int c);
    logic s;
    c = 0;
    do begin
      tick(1);
      c++;
      s = k == 0 ? DMA_DONE : k == 1 ? !ACK_N :
        k == 2 ? !PORT_WRITE_STROBE_N : !MASTER_WRITE_STROBE_N;
    end while (s !== 1'h1 && c < 50);
  endtask
  // e of 0 skips the length check
  task automatic lr_tail(input logic [LBD_AW-1:0] a, input int e);
    wait_for(0, n);
    chk(n < 50 && (e == 0 || n == e), "read length");
    @(posedge CLK);
    LR_REQ <= 1'h0;
    #1;
    chk(RD_VALID === 1'h1 && RD_DATA === (a ^ K), "read word");
  endtask
  task automatic do_lr(input logic [LBD_AW-1:0] a, input logic [3:0] w);
    @(posedge CLK);
    waits <= w;
    LR_ADDR <= a;
    LR_REQ <= 1'h1;
    lr_tail(a, 4 + w);
  endtask
  task automatic t_grant;
    @(posedge CLK);
    LR_ADDR <= 16'h0040;
    LR_REQ <= 1'h1;
    tick(8);
    chk(MASTER_READ_STROBE_OE === 1'h0 && RD_VALID === 1'h0, "no grant");
    chk(BUS_REQUEST_OUT === 1'h1 && MASTER_WRITE_STROBE_OE === 1'h0, "request");
    @(posedge CLK);
    BUS_GRANT <= 1'h1;
    lr_tail(16'h0040, 4);
    chk(MASTER_READ_STROBE_OE === 1'h1 && MASTER_WRITE_STROBE_OE === 1'h1, "strobe driven");
  endtask
  task automatic t_buf;
    @(posedge CLK);
    RD_READY <= 1'h0;
    do_lr(16'h0010, 0);
    // second word queues behind the stalled head
    @(posedge CLK);
    LR_ADDR <= 16'h0011;
    LR_REQ <= 1'h1;
    wait_for(0, n);
    chk(n == 4, "queued read length");
    @(posedge CLK);
    LR_REQ <= 1'h0;
    #1;
    chk(RD_VALID === 1'h1 && RD_DATA === (16'h0010 ^ K), "head kept");
    @(posedge CLK);
    LR_ADDR <= 16'h0012;
    LR_REQ <= 1'h1;
    wait_for(0, n);
    chk(n == 50, "read while full");
    @(posedge CLK);
    RD_READY <= 1'h1;
    #1;
    chk(RD_VALID === 1'h1 && RD_DATA === (16'h0010 ^ K), "first word");
    tick(1);
    chk(RD_DATA === (16'h0011 ^ K), "second word");
    lr_tail(16'h0012, 0);
    tick(2);
    chk(RD_VALID === 1'h0, "drained");
  endtask
  task automatic t_lw;
    @(posedge CLK);
    LW_REQ <= 1'h1;
    wait_for(0, n);
    chk(n == 4, "write length");
    @(posedge CLK);
    LW_REQ <= 1'h0;
    chk(wr_q === 16'hBEEF && wa_q === 16'h0456, "write word");
  endtask
  task automatic t_remote;
    @(posedge CLK);
    REM_LOAD <= 1'h1;
    @(posedge CLK);
    REM_LOAD <= 1'h0;
    LATCH_READ_DONE <= 1'h1;
    @(posedge CLK);
    LATCH_READ_DONE <= 1'h0;
    wait_for(2, n);
    chk(n == 2, "refill start");
    tick(2);
    chk(PORT_WRITE_STROBE_N === 1'h1 && lat_q === (16'h0800 ^ K), "latch");
    @(posedge CLK);
    LATCH_WRITE_DONE <= 1'h1;
    @(posedge CLK);
    LATCH_WRITE_DONE <= 1'h0;
    wait_for(3, n);
    chk(n == 2 && PORT_READ_ENABLE_N === 1'h0 && AD_LO_OE === 1'h0, "rw");
    tick(2);
    chk(wr_q === 16'hCAFE && wa_q === 16'h0801, "remote word");
  endtask
  task automatic t_slave;
    @(posedge CLK);
    CS_N <= 1'h0;
    SLAVE_WR_N <= 1'h0;
    host_oe <= 1'h1;
    REGISTER_ADDRESS_INPUTS <= 4'h9;
    wait_for(1, n);
    chk(n == 2, "write ack");
    @(posedge CLK);
    SLAVE_WR_N <= 1'h1;
    tick(1);
    chk(ACK_N === 1'h1 && REG_WE === 1'h1 && REG_WDATA === 8'h5D, "reg write");
    chk(REG_ADDR === 4'h9, "reg addr");
    @(posedge CLK);
    CS_N <= 1'h1;
    host_oe <= 1'h0;
    REGISTER_ADDRESS_INPUTS <= 4'h2;
    tick(2);
    chk(REG_ADDR === 4'h9 && REG_WE === 1'h0, "addr held");
    @(posedge CLK);
    CS_N <= 1'h0;
    SLAVE_RD_N <= 1'h0;
    REGISTER_ADDRESS_INPUTS <= 4'h6;
    wait_for(1, n);
    chk(n == 2, "read ack");
    tick(1);
    chk(AD_LO_OE === 1'h1 && AD_HI_OE === 1'h0 && AD_O[7:0] === 8'hC6, "reg rd");
    @(posedge CLK);
    SLAVE_RD_N <= 1'h1;
    CS_N <= 1'h1;
    tick(1);
    chk(ACK_N === 1'h1 && AD_LO_OE === 1'h0, "ack release");
  endtask
  initial begin
    forever #5 CLK = ~CLK;
  end
  // run takes well under 1000 cycles
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      $display("CHECK FAILED %0t timeout", $time);
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge CLK);
    RST <= 1'h0;
    #1;
    chk(ACK_N === 1'h1 && BUS_REQUEST_OUT === 1'h0 && MASTER_READ_STROBE_N === 1'h1, "rst");
    t_grant();
    do_lr(16'h0123, 2);
    do_lr(16'h0FFF, 1);
    t_buf();
    t_lw();
    t_remote();
    t_slave();
    give_verdict();
  end
endmodule
